// >>> core/adc_conversion_control.sv
// Run control, sequencing and result arbitration for the 10-bit converter.
`timescale 1ns/1ns
module adc_conversion_control #(
  parameter int unsigned SAMPLE_LEN = adcc_pkg::SAMPLE_CYCLES
) (
  input  wire logic                          mclk,
  input  wire logic                          srst,
  input  wire logic                          standby,
  input  wire logic                          mode_wr,
  input  wire logic [adcc_pkg::MODE_BITS-1:0] mode_wdata,
  input  wire logic                          sel_wr,
  input  wire logic [adcc_pkg::CH_BITS-1:0]   sel_wdata,
  input  wire logic                          result_rd,
  input  wire logic                          flag_clr,
  input  wire logic                          comp_in,
  output logic [adcc_pkg::MODE_BITS-1:0]      converter_mode_reg,
  output logic [adcc_pkg::CH_BITS-1:0]        input_select_reg,
  output logic [adcc_pkg::RES_BITS-1:0]       conversion_result_reg,
  output logic                               conversion_done_flag,
  output logic                               conversion_done_irq,
  output logic                               sampling,
  output logic                               converting,
  output logic [adcc_pkg::RES_BITS-1:0]       dac_trial,
  output logic [3:0]                         analog_input_pins
);
  // ==========================================================
  // State
  typedef struct packed {
    adcc_pkg::adcc_phase_t             phase;
    logic [7:0]                        count;
    logic [adcc_pkg::MODE_BITS-1:0]    mode;
    logic [adcc_pkg::CH_BITS-1:0]      sel;
    logic [adcc_pkg::RES_BITS-1:0]     result;
    logic [adcc_pkg::RES_BITS-1:0]     pend;
    logic                              pend_vld;
    logic                              flag;
    logic                              irq;
  } adcc_st_t;

  adcc_st_t   st;
  adcc_st_t   next_st;
  adcc_sar_if sar_bus();

  // ==========================================================
  // Parameter checks
  if (SAMPLE_LEN < 1 || SAMPLE_LEN > 255)
  begin : g_bad_len
    $error("adc_conversion_control: sampling length out of range");
  end

  if ($bits(analog_input_pins) != (1 << adcc_pkg::CH_BITS))
  begin : g_bad_pins
    $error("adc_conversion_control: one input pin per select code");
  end

  // ==========================================================
  // Decoders
  function automatic logic [3:0] adcc_onehot(input logic [1:0] code);
    adcc_onehot = 4'h1 << code;
  endfunction

  function automatic logic adcc_in_phase(
    input adcc_pkg::adcc_phase_t cur,
    input adcc_pkg::adcc_phase_t want
  );
    adcc_in_phase = (cur == want);
  endfunction

  // ==========================================================
  // Control terms
  logic       run;
  logic       cfg_wr;
  logic       halt;
  logic       sample_last;
  logic [3:0] sel_hot;

  assign run         = st.mode[adcc_pkg::RUN_BIT];
  assign cfg_wr      = mode_wr | sel_wr;
  assign halt        = cfg_wr | standby | ~run;
  assign sample_last = adcc_in_phase(st.phase, adcc_pkg::adcc_sample)
                       & (st.count == 8'(SAMPLE_LEN - 1));
  assign sel_hot     = adcc_onehot(st.sel);

  // ==========================================================
  // Engine
  adcc_sar u_sar (
    .mclk (mclk),
    .srst (srst),
    .sar  (sar_bus.sar)
  );

  assign sar_bus.comp_in = comp_in;
  assign sar_bus.start   = ~halt & sample_last;
  assign sar_bus.abort   = halt;

  // ==========================================================
  // Sequencer
  always_comb
  begin
    next_st = st;
    next_st.irq = 1'b0;
    // Register writes and the flag clear land at once.
    if (flag_clr)
    begin
      next_st.flag = 1'b0;
    end
    if (mode_wr)
    begin
      next_st.mode = mode_wdata;
    end
    if (sel_wr)
    begin
      next_st.sel = sel_wdata;
    end
    // A deferred store lands in the first cycle without a read or a config write; a config write drops it.
    if (st.pend_vld && cfg_wr)
    begin
      next_st.pend_vld = 1'b0;
    end
    else if (st.pend_vld && !result_rd)
    begin
      next_st.result = st.pend;
      next_st.pend_vld = 1'b0;
    end

    // Phase sequencing.
    if (halt)
    begin
      // Abort: drop the running conversion; a deferred store is dropped only by a config write.
      next_st.phase = adcc_pkg::adcc_idle;
      next_st.count = 8'h00;
    end
    else
    begin
      unique case (st.phase)
        adcc_pkg::adcc_idle:
        begin
          next_st.phase = adcc_pkg::adcc_sample;
          next_st.count = 8'h00;
        end
        adcc_pkg::adcc_sample:
        begin
          if (sample_last)
            next_st.phase = adcc_pkg::adcc_approx;
          else
            next_st.count = st.count + 8'h01;
        end
        adcc_pkg::adcc_approx:
        begin
          if (sar_bus.done)
            next_st.phase = adcc_pkg::adcc_store;
        end
        adcc_pkg::adcc_store:
        begin
          if (result_rd)
          begin
            next_st.pend = sar_bus.value;
            next_st.pend_vld = 1'b1;
          end
          else
            next_st.result = sar_bus.value;
          next_st.flag = 1'b1;
          next_st.irq = 1'b1;
          next_st.phase = adcc_pkg::adcc_sample;
          next_st.count = 8'h00;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st <= '0;
      st.mode <= adcc_pkg::MODE_BITS'(adcc_pkg::MODE_RESET);
      st.sel <= adcc_pkg::CH_BITS'(adcc_pkg::SEL_RESET);
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // Register views
  assign converter_mode_reg    = st.mode;
  assign input_select_reg      = st.sel;
  assign conversion_result_reg = st.result;
  assign conversion_done_flag  = st.flag;
  assign conversion_done_irq   = st.irq;

  // ==========================================================
  // Phase status and ladder code
  assign sampling   = adcc_in_phase(st.phase, adcc_pkg::adcc_sample);
  assign converting = ~adcc_in_phase(st.phase, adcc_pkg::adcc_idle);
  assign dac_trial  = sar_bus.trial;

  // ==========================================================
  // Analog input routing
  for (genvar i = 0; i < $bits(analog_input_pins); i++)
  begin : g_pin
    assign analog_input_pins[i] = converting & sel_hot[i];
  end
endmodule // adc_conversion_control

// >>> core/adcc_pkg.sv
// Package of constants and types for the conversion control block.
package adcc_pkg;
  localparam int unsigned RES_BITS     = 10;
  localparam int unsigned CH_BITS      = 2;
  localparam int unsigned MODE_BITS    = 8;
  localparam int unsigned RUN_BIT      = 7;
  localparam int unsigned SEL_RESET    = 0;
  localparam int unsigned MODE_RESET   = 0;
  localparam int unsigned SAMPLE_DIV   = 10;
  localparam int unsigned BIT_CYCLES   = 9;
  localparam int unsigned CONV_TIME_NS = 5000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CONV_CYCLES  = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_CYCLES = CONV_CYCLES / SAMPLE_DIV;

  typedef enum logic [1:0] {
    adcc_idle,
    adcc_sample,
    adcc_approx,
    adcc_store
  } adcc_phase_t;
endpackage

// >>> core/adcc_sar.sv
// Successive approximation register stepping from bit 9 down to bit 0.
`timescale 1ns/1ns
module adcc_sar #(
  parameter int unsigned STEP_CYCLES = adcc_pkg::BIT_CYCLES
) (
  input  wire logic mclk,
  input  wire logic srst,
  adcc_sar_if.sar   sar
);
  typedef struct packed {
    logic       busy;
    logic [3:0] bit_idx;
    logic [7:0] step;
    logic [9:0] acc;
    logic       done;
  } adcc_sar_st_t;

  adcc_sar_st_t st;
  adcc_sar_st_t next_st;

  if (STEP_CYCLES < 1 || STEP_CYCLES > 255)
  begin : g_bad_step
    $error("adcc_sar: step cycle count out of range");
  end

  assign sar.trial = st.acc | (st.busy ? (10'h001 << st.bit_idx) : 10'h000);
  assign sar.value = st.acc;
  assign sar.done  = st.done;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (sar.abort)
    begin
      next_st.busy = 1'b0;
    end
    else if (sar.start)
    begin
      next_st.busy = 1'b1;
      next_st.bit_idx = 4'(adcc_pkg::RES_BITS - 1);
      next_st.step = 8'h00;
      next_st.acc = 10'h000;
    end
    else if (st.busy)
    begin
      if (st.step == 8'(STEP_CYCLES - 1))
      begin
        next_st.step = 8'h00;
        if (sar.comp_in)
          next_st.acc = sar.trial;
        if (st.bit_idx == 4'h0)
        begin
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
        end
        else
          next_st.bit_idx = st.bit_idx - 4'h1;
      end
      else
        next_st.step = st.step + 8'h01;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end
endmodule // adcc_sar

// >>> core/adcc_sar_if.sv
// Interface between the sequencer and the successive approximation engine.
`timescale 1ns/1ns
interface adcc_sar_if;
  logic       start;
  logic       abort;
  logic       comp_in;
  logic [9:0] trial;
  logic [9:0] value;
  logic       done;
  modport seq (output start, output abort, input trial, input value,
               input done);
  modport sar (input start, input abort, input comp_in, output trial,
               output value, output done);
endinterface

// >>> test/adc_conversion_control_tb.sv
// Self-checking bench for the conversion control block.
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module adc_conversion_control_tb;
  logic mclk = 1'b0, srst = 1'b1, standby = 1'b0, mode_wr = 1'b0;
  logic sel_wr = 1'b0, result_rd = 1'b0, flag_clr = 1'b0, comp_in;
  logic [7:0]  mode_wdata = 8'h00, converter_mode_reg;
  logic [1:0]  sel_wdata = 2'h0, input_select_reg;
  logic [9:0]  conversion_result_reg, dac_trial;
  logic        conversion_done_flag, conversion_done_irq, sampling, converting;
  logic [3:0]  analog_input_pins;
  logic [39:0] lv = {10'h000, 10'h3ff, 10'h0f3, 10'h2a5};
  int          errors = 0, n_compared = 0, n;
  // ==========================================================
  // Clock, design, comparator and access tasks.
  initial forever #25 mclk = ~mclk;
  adc_conversion_control u_dut (.mclk, .srst, .standby, .mode_wr,
    .mode_wdata, .sel_wr, .sel_wdata, .result_rd, .flag_clr, .comp_in,
    .converter_mode_reg, .input_select_reg, .conversion_result_reg,
    .conversion_done_flag, .conversion_done_irq, .sampling, .converting,
    .dac_trial, .analog_input_pins);
  adcc_comp_model u_cmp (.levels(lv), .dac_trial, .analog_input_pins,
    .comp_in);
  task step(int k); repeat (k) @(posedge mclk); #2; endtask
  task wr_mode(logic [7:0] d); mode_wdata = d; mode_wr = 1; step(1); mode_wr = 0; endtask
  task wr_sel(logic [1:0] c); sel_wdata = c; sel_wr = 1; step(1); sel_wr = 0; endtask
  task clr; flag_clr = 1; step(1); flag_clr = 0; endtask
  task wait_irq;
    n = 0;
    do begin step(1); n++; end while (!conversion_done_irq && n < 400);
    if (conversion_done_irq !== 1'b1)
      errors++;
  endtask
  task wrap_up;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #(5000 * 50);
    errors++;
    wrap_up;
  end
  initial
  begin
    step(5);
    srst = 0;
    `CHK(converter_mode_reg, 8'h00)
    `CHK(input_select_reg, 2'h0)
    `CHK(conversion_done_flag, 1'b0)
    wr_mode(8'h80);
    for (int c = 0; c < 4; c++)
    begin
      wr_sel(c[1:0]);
      wait_irq;
      clr;
      wait_irq;
      `CHK(conversion_done_irq, 1'b1)
      `CHK(conversion_result_reg, lv[c*10 +: 10])
      `CHK(conversion_done_flag, 1'b1)
      `CHK(analog_input_pins, 4'h1 << c)
      `CHK(sampling, 1'b1)
      `CHK(dac_trial, lv[c*10 +: 10])
    end
    $display("channel test done");
    wr_mode(8'h80);
    `CHK(converter_mode_reg, 8'h80)
    `CHK(conversion_done_flag, 1'b1)
    `CHK(conversion_result_reg, lv[39:30])
    clr;
    `CHK(conversion_done_flag, 1'b0)
    wr_sel(2'h0);
    result_rd = 1;
    wait_irq;
    `CHK(conversion_result_reg, lv[39:30])
    step(1);
    result_rd = 0;
    step(2);
    `CHK(conversion_result_reg, lv[9:0])
    $display("read conflict test done");
    wait_irq;
    wait_irq;
    lv[9:0] = 10'h0aa;
    clr;
    step(n - 2);
    wr_sel(2'h0);
    `CHK(conversion_done_irq, 1'b0)
    `CHK(conversion_done_flag, 1'b0)
    `CHK(conversion_result_reg, 10'h2a5)
    wait_irq;
    `CHK(conversion_result_reg, 10'h0aa)
    $display("write conflict test done");
    clr;
    standby = 1;
    step(250);
    `CHK(conversion_done_flag, 1'b0)
    `CHK(converting, 1'b0)
    standby = 0;
    wait_irq;
    `CHK(conversion_done_irq, 1'b1)
    wr_mode(8'h00);
    `CHK(conversion_result_reg, 10'h0aa)
    standby = 1;
    clr;
    standby = 0;
    step(250);
    `CHK(conversion_done_flag, 1'b0)
    `CHK(converting, 1'b0)
    $display("standby and stop test done");
    wrap_up;
  end
endmodule // adc_conversion_control_tb

// >>> test/adcc_comp_model.sv
// Comparator model giving one analog level per input pin.
`timescale 1ns/1ns
module adcc_comp_model (
  input  wire logic [39:0] levels,
  input  wire logic [9:0]  dac_trial,
  input  wire logic [3:0]  analog_input_pins,
  output logic             comp_in
);
  // ==========================================================
  // Comparator: input at or above trial reads as one.
  always_comb
  begin
    comp_in = 1'b0;
    for (int i = 0; i < 4; i++)
      if (analog_input_pins[i] && levels[i*10 +: 10] >= dac_trial)
        comp_in = 1'b1;
  end
endmodule // adcc_comp_model

// >>> test/adcc_monitor.sv
// Assertion checker for the conversion control block.
`timescale 1ns/1ns
module adcc_monitor #(
  parameter int unsigned SAMPLE_LEN = 10
) (
  input wire logic                          mclk,
  input wire logic                          srst,
  input wire logic                          standby,
  input wire logic                          mode_wr,
  input wire logic                          sel_wr,
  input wire logic                          result_rd,
  input wire logic                          flag_clr,
  input wire logic [adcc_pkg::RES_BITS-1:0] conversion_result_reg,
  input wire logic                          conversion_done_flag,
  input wire logic                          conversion_done_irq,
  input wire logic                          sampling,
  input wire logic                          converting
);
  // ==========================================================
  // Sampling phase length counter and abort marker.
  logic [7:0] scnt;
  logic       hit;
  always_ff @(posedge mclk)
  begin
    scnt <= (srst || !sampling) ? 8'h00 : scnt + 8'h01;
    hit  <= (srst || !sampling) ? 1'b0 : hit | mode_wr | sel_wr | standby;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  irq_pulse_a: assert property (conversion_done_irq |=> !conversion_done_irq)
    else $error("done request longer than one cycle");
  irq_flag_a: assert property ($rose(conversion_done_flag) |-> conversion_done_irq)
    else $error("flag set without a stored result");
  standby_halt_a: assert property (standby |=> !converting && !conversion_done_irq)
    else $error("activity during standby");
  cfg_wins_a: assert property ((mode_wr || sel_wr) |=>
    !conversion_done_irq && $stable(conversion_result_reg))
    else $error("store not discarded on config write");
  read_hold_a: assert property (result_rd |=> $stable(conversion_result_reg))
    else $error("result changed under a read");
  mode_flag_a: assert property (mode_wr && !flag_clr && conversion_done_flag |=> conversion_done_flag)
    else $error("mode write cleared the flag");
  flag_clear_a: assert property (flag_clr |=> conversion_done_flag == conversion_done_irq)
    else $error("flag clear misbehaved");
  sample_len_a: assert property ($fell(sampling) && !hit |-> scnt == SAMPLE_LEN)
    else $error("sampling phase length wrong");

  sequence store_s;
    conversion_done_irq && conversion_done_flag;
  endsequence
  sequence resample_s;
    sampling && converting;
  endsequence
  restart_a: assert property (store_s |-> resample_s)
    else $error("no new conversion after a store");
  cfg_abort_a: assert property ((mode_wr || sel_wr) |=> !converting)
    else $error("conversion not aborted by config write");
endmodule // adcc_monitor

bind adc_conversion_control adcc_monitor #(.SAMPLE_LEN(SAMPLE_LEN)) u_mon (
  .mclk, .srst, .standby, .mode_wr, .sel_wr, .result_rd, .flag_clr,
  .conversion_result_reg, .conversion_done_flag, .conversion_done_irq,
  .sampling, .converting);
